//--- hw/cief_map.svh
// Purpose: offsets, bit positions, reset values of the interrupt front end
// Assumes: register byte address is four times the index
// Notes: included by the front end and its package users
`ifndef CIEF_MAP_SVH
`define CIEF_MAP_SVH

// register indices
`define CIEF_TIMER_AND_EXT_INT_CONTROL_IDX 8'h88
`define CIEF_IEN3_IDX 8'h9A
`define CIEF_INTERRUPT_ENABLE_SECOND_IDX 8'hA8
`define CIEF_INTERRUPT_ENABLE_THIRD_IDX 8'hB8
`define CIEF_XREQ_IDX 8'hC0
`define CIEF_PRIO_IDX 8'hF0
`define CIEF_STAT_IDX 8'hF1

// reset values
`define CIEF_TIMER_AND_EXT_INT_CONTROL_RST 8'h00
`define CIEF_IEN_RST 8'h00
`define CIEF_XREQ_RST 8'h00
`define CIEF_PRIO_RST 12'h000

// first enable register
`define CIEF_GLB_BIT 7
`define CIEF_ESA_BIT 4
`define CIEF_ETB_BIT 3
`define CIEF_EX1_BIT 2
`define CIEF_ETA_BIT 1
`define CIEF_EX0_BIT 0
// second enable register: external 2..6 at bits 1..5
`define CIEF_EX2_BIT 1
// third enable register
`define CIEF_ESB_BIT 0
// timer control register
`define CIEF_TFB_BIT 7
`define CIEF_TFA_BIT 5
`define CIEF_IE1_BIT 3
`define CIEF_IT1_BIT 2
`define CIEF_IE0_BIT 1
`define CIEF_IT0_BIT 0
// request register: external 2..6 at bits 1..5
`define CIEF_IEX2_BIT 1

// source indices
`define CIEF_SRC_EX0 0
`define CIEF_SRC_TA 1
`define CIEF_SRC_EX1 2
`define CIEF_SRC_TB 3
`define CIEF_SRC_SA 4
`define CIEF_SRC_SB 5
`define CIEF_SRC_EX2 6
`define CIEF_NUM_SRC 11

`endif

//--- hw/cief_pkg.sv
// Purpose: types of the interrupt front end
// Assumes: nothing
// Notes: constants live in cief_map.svh
package cief_pkg;
    typedef enum logic [2:0] {
        ACK_IDLE = 3'b001,
        ACK_POLL = 3'b010,
        ACK_REQ = 3'b100
    } cief_ack_e;
    typedef logic [3:0] cief_src_t;
    typedef logic [1:0] cief_level_t;
    typedef logic [15:0] cief_vector_t;
endpackage

//--- hw/cief_edge.sv
// Purpose: optional two-stage synchroniser with edge detection
// Assumes: SYNC=1 for pins, SYNC=0 for same-clock logic
// Notes: rise and fall are one-cycle pulses on the settled level
`timescale 1ns/1ps
module cief_edge #(
    parameter int SYNC = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic din,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta;
    logic next_meta;
    logic settled;
    logic prev;
    logic next_prev;

    generate
        if (SYNC != 0) begin : g_sync
            logic stage;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta <= 1'b1;
                    stage <= 1'b1;
                end else if (ce) begin
                    meta <= next_meta;
                    stage <= meta;
                end
            end
            assign settled = stage;
        end else begin : g_direct
            assign meta = 1'b0;
            assign settled = din;
        end
    endgenerate

    always_comb begin
        next_meta = din;
        next_prev = settled;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= (SYNC != 0);
        end else if (ce) begin
            prev <= next_prev;
        end
    end

    assign level = settled;
    assign rise = settled & ~prev;
    assign fall = ~settled & prev;
endmodule

//--- hw/cief_top.sv
// Purpose: interrupt enables, request flags, polling and call request
// Assumes: sequencer pulses machine_cycle_stb once per machine cycle
// Notes: APB slave, zero wait states; ce low freezes everything
`timescale 1ns/1ps
`include "cief_map.svh"
module cief_top #(
    parameter int ADDR_W = 12,
    // vector of source i at bits [16*i +: 16]
    parameter logic [16*`CIEF_NUM_SRC-1:0] VECTORS = {
        16'h0050, 16'h0048, 16'h0040, 16'h0038, 16'h0030, 16'h0028,
        16'h0020, 16'h0018, 16'h0010, 16'h0008, 16'h0000},
    // source polled at position k at bits [4*k +: 4], k=0 first
    parameter logic [4*`CIEF_NUM_SRC-1:0] POLL_ORDER = {
        4'hA, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0}
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_zero_pin,
    input wire logic ext_one_pin,
    input wire logic ext_two_pin,
    input wire logic ext_three_pin,
    input wire logic ext_four_src,
    input wire logic ext_five_src,
    input wire logic ext_six_src,
    input wire logic timer_a_ovf_evt,
    input wire logic timer_b_ovf_evt,
    input wire logic serial_a_irq,
    input wire logic serial_b_irq,
    input wire logic machine_cycle_stb,
    input wire logic call_taken,
    input wire logic return_from_interrupt_stb,
    output logic irq_call_req,
    output cief_pkg::cief_vector_t irq_vector,
    output cief_pkg::cief_src_t irq_source
);
    import cief_pkg::*;

    localparam int NS = `CIEF_NUM_SRC;

    // ---- external inputs: pins synchronised, peripherals direct
    logic [6:0] ext_in;
    logic [6:0] ext_lvl;
    logic [6:0] ext_rise;
    logic [6:0] ext_fall;

    assign ext_in = {ext_six_src, ext_five_src, ext_four_src,
                     ext_three_pin, ext_two_pin, ext_one_pin, ext_zero_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_ext
            cief_edge #(
                .SYNC(gi < 4 ? 1 : 0)
            ) u_edge (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .din(ext_in[gi]),
                .level(ext_lvl[gi]),
                .rise(ext_rise[gi]),
                .fall(ext_fall[gi])
            );
        end
    endgenerate

    // ---- registers
    logic [7:0] timer_and_ext_int_control;
    logic [7:0] next_timer_and_ext_int_control;
    logic [7:0] interrupt_enable_second;
    logic [7:0] next_interrupt_enable_second;
    logic [7:0] interrupt_enable_third;
    logic [7:0] next_interrupt_enable_third;
    logic [7:0] ien3;
    logic [7:0] next_ien3;
    logic [7:0] xreq;
    logic [7:0] next_xreq;
    logic [11:0] prio;
    logic [11:0] next_prio;

    // ---- apb decode
    logic [7:0] idx;
    logic hit_timer_and_ext_int_control;
    logic hit_interrupt_enable_second;
    logic hit_interrupt_enable_third;
    logic hit_ien3;
    logic hit_xreq;
    logic hit_prio;
    logic hit_stat;
    logic mapped;
    logic wr_en;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    assign idx = paddr[9:2];
    always_comb begin
        hit_timer_and_ext_int_control = (idx == `CIEF_TIMER_AND_EXT_INT_CONTROL_IDX);
        hit_interrupt_enable_second = (idx == `CIEF_INTERRUPT_ENABLE_SECOND_IDX);
        hit_interrupt_enable_third = (idx == `CIEF_INTERRUPT_ENABLE_THIRD_IDX);
        hit_ien3 = (idx == `CIEF_IEN3_IDX);
        hit_xreq = (idx == `CIEF_XREQ_IDX);
        hit_prio = (idx == `CIEF_PRIO_IDX);
        hit_stat = (idx == `CIEF_STAT_IDX);
        mapped = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00)
            && (hit_timer_and_ext_int_control | hit_interrupt_enable_second | hit_interrupt_enable_third | hit_ien3 | hit_xreq
                | hit_prio | hit_stat);
        wr_en = psel & penable & pready & pwrite & mapped;
    end

    // ---- acknowledge state
    cief_ack_e state;
    cief_ack_e next_state;
    logic [NS-1:0] sample;
    logic [NS-1:0] next_sample;
    logic [3:0] in_service;
    logic [3:0] next_in_service;
    logic [1:0] req_level;
    logic [1:0] next_req_level;
    logic next_irq_call_req;
    cief_vector_t next_irq_vector;
    cief_src_t next_irq_source;

    // ---- status read value
    logic [31:0] stat_word;
    assign stat_word = {22'h000000, irq_call_req, state == ACK_REQ,
                        irq_source, in_service};

    always_comb begin
        next_pready = psel & ~penable;
        next_pslverr = psel & ~penable & ~mapped;
        next_prdata = 32'h00000000;
        if (psel && !penable && !pwrite && mapped) begin
            case (1'b1)
                hit_timer_and_ext_int_control: next_prdata = {24'h000000, timer_and_ext_int_control};
                hit_interrupt_enable_second: next_prdata = {24'h000000, interrupt_enable_second};
                hit_interrupt_enable_third: next_prdata = {24'h000000, interrupt_enable_third};
                hit_ien3: next_prdata = {31'h00000000, ien3[0]};
                hit_xreq: next_prdata = {24'h000000, xreq};
                hit_prio: next_prdata = {20'h00000, prio};
                hit_stat: next_prdata = stat_word;
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    // ---- priority of a source through its group
    function automatic logic [1:0] src_level(input logic [3:0] s,
                                             input logic [11:0] p);
        logic [2:0] grp;
        grp = 3'd0;
        case (s)
            4'h0, 4'h5: grp = 3'd0;
            4'h1, 4'h6: grp = 3'd1;
            4'h2, 4'h7: grp = 3'd2;
            4'h3, 4'h8: grp = 3'd3;
            4'h4, 4'h9: grp = 3'd4;
            default: grp = 3'd5;
        endcase
        return p[2*grp +: 2];
    endfunction

    // ---- live flag vector and enables per source
    logic [NS-1:0] flags;
    logic [NS-1:0] enables;
    always_comb begin
        flags = {xreq[5:1], serial_b_irq, serial_a_irq,
                 timer_and_ext_int_control[`CIEF_TFB_BIT], timer_and_ext_int_control[`CIEF_IE1_BIT],
                 timer_and_ext_int_control[`CIEF_TFA_BIT], timer_and_ext_int_control[`CIEF_IE0_BIT]};
        enables = {interrupt_enable_third[5:1], ien3[`CIEF_ESB_BIT],
                   interrupt_enable_second[`CIEF_ESA_BIT], interrupt_enable_second[`CIEF_ETB_BIT],
                   interrupt_enable_second[`CIEF_EX1_BIT], interrupt_enable_second[`CIEF_ETA_BIT],
                   interrupt_enable_second[`CIEF_EX0_BIT]};
    end

    // ---- polling of the sampled flags
    logic win_found;
    logic [3:0] win_src;
    logic [1:0] win_level;
    logic [1:0] cur_level;
    logic busy;
    always_comb begin
        logic [3:0] s;
        logic [1:0] l;
        s = 4'h0;
        l = 2'd0;
        win_found = 1'b0;
        win_src = 4'h0;
        win_level = 2'd0;
        busy = |in_service;
        cur_level = in_service[3] ? 2'd3 : in_service[2] ? 2'd2
            : in_service[1] ? 2'd1 : 2'd0;
        for (int k = 0; k < NS; k++) begin
            s = POLL_ORDER[4*k +: 4];
            l = src_level(s, prio);
            // global gate, then per-source enable
            if (interrupt_enable_second[`CIEF_GLB_BIT] && sample[s] && enables[s]
                && (!busy || l > cur_level)
                && (!win_found || l > win_level)) begin
                win_found = 1'b1;
                win_src = s;
                win_level = l;
            end
        end
    end

    // ---- acknowledge sequence
    logic take;
    assign take = (state == ACK_REQ) && call_taken;

    always_comb begin
        next_state = state;
        next_sample = sample;
        next_irq_call_req = irq_call_req;
        next_irq_vector = irq_vector;
        next_irq_source = irq_source;
        next_req_level = req_level;
        next_in_service = in_service;
        if (return_from_interrupt_stb) begin
            // leave the innermost routine
            if (in_service[3]) next_in_service[3] = 1'b0;
            else if (in_service[2]) next_in_service[2] = 1'b0;
            else if (in_service[1]) next_in_service[1] = 1'b0;
            else next_in_service[0] = 1'b0;
        end
        case (state)
            ACK_IDLE: begin
                if (machine_cycle_stb) begin
                    next_sample = flags;
                    next_state = ACK_POLL;
                end
            end
            ACK_POLL: begin
                if (win_found) begin
                    // one cycle of detection before the call
                    next_irq_call_req = 1'b1;
                    next_irq_vector = VECTORS[16*win_src +: 16];
                    next_irq_source = win_src;
                    next_req_level = win_level;
                    next_state = ACK_REQ;
                end else begin
                    next_state = ACK_IDLE;
                end
            end
            ACK_REQ: begin
                if (call_taken) begin
                    next_irq_call_req = 1'b0;
                    next_in_service[req_level] = 1'b1;
                    next_state = ACK_IDLE;
                end
            end
            default: begin
                next_state = ACK_IDLE;
                next_irq_call_req = 1'b0;
            end
        endcase
    end

    // ---- flag and register next values; hardware set beats clear
    always_comb begin
        logic [NS-1:0] clr;
        clr = '0;
        if (take) clr[irq_source] = 1'b1;
        next_interrupt_enable_second = wr_en && hit_interrupt_enable_second ? pwdata[7:0] : interrupt_enable_second;
        next_interrupt_enable_third = wr_en && hit_interrupt_enable_third ? pwdata[7:0] : interrupt_enable_third;
        next_ien3 = wr_en && hit_ien3 ? {7'h00, pwdata[0]} : ien3;
        next_prio = wr_en && hit_prio ? pwdata[11:0] : prio;

        next_timer_and_ext_int_control = wr_en && hit_timer_and_ext_int_control ? pwdata[7:0] : timer_and_ext_int_control;
        next_timer_and_ext_int_control[`CIEF_TFA_BIT] = (next_timer_and_ext_int_control[`CIEF_TFA_BIT]
            & ~clr[`CIEF_SRC_TA]) | timer_a_ovf_evt;
        next_timer_and_ext_int_control[`CIEF_TFB_BIT] = (next_timer_and_ext_int_control[`CIEF_TFB_BIT]
            & ~clr[`CIEF_SRC_TB]) | timer_b_ovf_evt;
        if (timer_and_ext_int_control[`CIEF_IT0_BIT]) begin
            next_timer_and_ext_int_control[`CIEF_IE0_BIT] = (next_timer_and_ext_int_control[`CIEF_IE0_BIT]
                & ~clr[`CIEF_SRC_EX0]) | ext_fall[0];
        end else begin
            next_timer_and_ext_int_control[`CIEF_IE0_BIT] = ~ext_lvl[0];
        end
        if (timer_and_ext_int_control[`CIEF_IT1_BIT]) begin
            next_timer_and_ext_int_control[`CIEF_IE1_BIT] = (next_timer_and_ext_int_control[`CIEF_IE1_BIT]
                & ~clr[`CIEF_SRC_EX1]) | ext_fall[1];
        end else begin
            next_timer_and_ext_int_control[`CIEF_IE1_BIT] = ~ext_lvl[1];
        end

        next_xreq = wr_en && hit_xreq ? pwdata[7:0] : xreq;
        next_xreq[7:6] = 2'b00;
        next_xreq[0] = 1'b0;
        // external 2, 3 on falling pin edge; 4..6 on rising edge
        next_xreq[5:1] = (next_xreq[5:1] & ~clr[NS-1:`CIEF_SRC_EX2])
            | {ext_rise[6:4], ext_fall[3:2]};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_and_ext_int_control <= `CIEF_TIMER_AND_EXT_INT_CONTROL_RST;
            interrupt_enable_second <= `CIEF_IEN_RST;
            interrupt_enable_third <= `CIEF_IEN_RST;
            ien3 <= `CIEF_IEN_RST;
            xreq <= `CIEF_XREQ_RST;
            prio <= `CIEF_PRIO_RST;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            timer_and_ext_int_control <= next_timer_and_ext_int_control;
            interrupt_enable_second <= next_interrupt_enable_second;
            interrupt_enable_third <= next_interrupt_enable_third;
            ien3 <= next_ien3;
            xreq <= next_xreq;
            prio <= next_prio;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ACK_IDLE;
            sample <= '0;
            irq_call_req <= 1'b0;
            irq_vector <= 16'h0000;
            irq_source <= 4'h0;
            req_level <= 2'd0;
            in_service <= 4'h0;
        end else if (ce) begin
            state <= next_state;
            sample <= next_sample;
            irq_call_req <= next_irq_call_req;
            irq_vector <= next_irq_vector;
            irq_source <= next_irq_source;
            req_level <= next_req_level;
            in_service <= next_in_service;
        end
    end
endmodule

//--- bench/cief_monitor.sv
// Purpose: port checks of the interrupt front end
// Assumes: ce held high during checked traffic
// Notes: bound to cief_top below the module
`timescale 1ns/1ps
`include "cief_map.svh"
module cief_monitor #(
    parameter int ADDR_W = 12,
    parameter logic [16*`CIEF_NUM_SRC-1:0] VECTORS = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic machine_cycle_stb,
    input wire logic call_taken,
    input wire logic irq_call_req,
    input wire cief_pkg::cief_vector_t irq_vector,
    input wire cief_pkg::cief_src_t irq_source
);
    import cief_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_unmapped_error: assert property (psel && !penable && ce &&
        !(paddr inside {12'h220, 12'h268, 12'h2A0, 12'h2E0, 12'h300,
        12'h3C0, 12'h3C4}) |=> pready && pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data outside answer");
    a_call_from_stb: assert property ($rose(irq_call_req) |-> $past(machine_cycle_stb, 2))
        else $error("call not two edges after sampling");
    a_vector_match: assert property (irq_call_req |-> irq_vector == VECTORS[16*irq_source +: 16])
        else $error("vector does not match source");
    a_call_holds: assert property (irq_call_req && !call_taken |=> irq_call_req && $stable(irq_source))
        else $error("call request dropped early");
    a_call_drops: assert property (irq_call_req && call_taken |=> !irq_call_req)
        else $error("call request kept after accept");
endmodule
bind cief_top cief_monitor #(.ADDR_W(ADDR_W), .VECTORS(VECTORS)) i_cief_monitor (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .machine_cycle_stb(machine_cycle_stb), .call_taken(call_taken),
    .irq_call_req(irq_call_req), .irq_vector(irq_vector),
    .irq_source(irq_source));

//--- bench/cief_seq_model.sv
// Purpose: sequencer stand-in: machine cycles, call accept, return
// Assumes: one machine cycle every four clocks
// Notes: lat sets clocks before a pending call is accepted
`timescale 1ns/1ps
module cief_seq_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_call_req,
    input wire logic [2:0] lat,
    input wire logic ret_go,
    output logic machine_cycle_stb,
    output logic call_taken,
    output logic ret_stb
);
    logic [1:0] phase;
    logic [2:0] wait_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 2'h0;
            wait_cnt <= 3'h0;
            machine_cycle_stb <= 1'b0;
            call_taken <= 1'b0;
            ret_stb <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            machine_cycle_stb <= (phase == 2'h3);
            call_taken <= 1'b0;
            ret_stb <= ret_go;
            if (irq_call_req && !call_taken) begin
                if (wait_cnt >= lat) begin
                    call_taken <= 1'b1;
                    wait_cnt <= 3'h0;
                end else begin
                    wait_cnt <= wait_cnt + 3'h1;
                end
            end
        end
    end
endmodule

//--- bench/testbench.sv
// Purpose: self-checking bench of the interrupt front end
// Assumes: default vectors 8*i and index poll order
// Notes: sequencer model accepts calls after a random delay
`timescale 1ns/1ps
`include "cief_map.svh"
module testbench;
    localparam logic [11:0] TC = 12'(4 * `CIEF_TIMER_AND_EXT_INT_CONTROL_IDX);
    localparam logic [11:0] E3 = 12'(4 * `CIEF_IEN3_IDX);
    localparam logic [11:0] E1 = 12'(4 * `CIEF_INTERRUPT_ENABLE_SECOND_IDX);
    localparam logic [11:0] E2 = 12'(4 * `CIEF_INTERRUPT_ENABLE_THIRD_IDX);
    localparam logic [11:0] XR = 12'(4 * `CIEF_XREQ_IDX);
    localparam logic [11:0] PR = 12'(4 * `CIEF_PRIO_IDX);
    localparam logic [11:0] REGS [5] = '{TC, E3, E1, E2, XR};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pin = 4'hF;
    logic [2:0] src = 3'h0;
    logic [1:0] tmr = 2'h0;
    logic [1:0] ser = 2'h0;
    logic ret_go = 1'b0;
    logic [2:0] lat = 3'h0;
    logic [31:0] prdata, r, v;
    logic pready, pslverr, irq_call_req, stb, taken, ret_stb, e;
    logic [15:0] irq_vector;
    logic [3:0] irq_source;
    logic [11:0] a;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    cief_top i_cief_top (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_zero_pin(pin[0]), .ext_one_pin(pin[1]), .ext_two_pin(pin[2]),
        .ext_three_pin(pin[3]), .ext_four_src(src[0]),
        .ext_five_src(src[1]), .ext_six_src(src[2]),
        .timer_a_ovf_evt(tmr[0]), .timer_b_ovf_evt(tmr[1]),
        .serial_a_irq(ser[0]), .serial_b_irq(ser[1]),
        .machine_cycle_stb(stb), .call_taken(taken), .return_from_interrupt_stb(ret_stb),
        .irq_call_req(irq_call_req), .irq_vector(irq_vector),
        .irq_source(irq_source));
    cief_seq_model i_cief_seq_model (.pclk(pclk), .presetn(presetn),
        .irq_call_req(irq_call_req), .lat(lat), .ret_go(ret_go),
        .machine_cycle_stb(stb), .call_taken(taken), .ret_stb(ret_stb));
    always #2.5 pclk = ~pclk;
    function automatic logic [31:0] msk(input logic [11:0] ad);
        return (ad == E3) ? 32'h1 : 32'hFF;
    endfunction
    function automatic logic [31:0] vec(input int s);
        return 32'(8 * s);
    endfunction
    task give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk_w(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            fails++;
            $display("MISMATCH at %0t got %h exp %h", $time, g, x);
        end
    endtask
    task chk_b(input logic g, input logic x);
        chk_w({31'h0, g}, {31'h0, x});
    endtask
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // hold request until ready is seen at a rising edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        chk_b(n < 50, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask
    task rd(input logic [11:0] ad, input logic [31:0] x);
        apb(1'b0, ad, 32'h0);
        chk_w(r, x);
    endtask
    task wait_call(input int s);
        int n;
        n = 0;
        while (irq_call_req !== 1'b1 && n < 300) begin
            n++;
            @(negedge pclk);
        end
        chk_w(32'(irq_source), 32'(s));
        chk_w(32'(irq_vector), vec(s));
        while (irq_call_req !== 1'b0 && n < 300) begin
            n++;
            @(negedge pclk);
        end
        chk_b(n < 300, 1'b1);
        @(posedge pclk);
    endtask
    task quiet(input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(negedge pclk);
            if (irq_call_req !== 1'b0) bad = 1'b1;
        end
        chk_b(bad, 1'b0);
        @(posedge pclk);
    endtask
    task do_return();
        @(posedge pclk);
        ret_go <= 1'b1;
        lat <= 3'($urandom_range(0, 5));
        @(posedge pclk);
        ret_go <= 1'b0;
    endtask
    task pulse(input logic [1:0] m);
        @(posedge pclk);
        tmr <= m;
        @(posedge pclk);
        tmr <= 2'h0;
    endtask
    task pins(input logic [3:0] p);
        @(posedge pclk);
        pin <= p;
        repeat (8) @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            chk_b(1'b0, 1'b1);
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h2891));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd(REGS[i], 32'h0);
        apb(1'b0, 12'h204, 32'h0);
        chk_b(e, 1'b1);
        apb(1'b1, E1 + 12'h2, 32'hFF);
        chk_b(e, 1'b1);
        rd(E1, 32'h0);
        for (int i = 0; i < 9; i++) begin
            v = $urandom;
            a = REGS[1 + i % 3];
            wr(a, v);
            rd(a, v & msk(a));
        end
        for (int i = 1; i < 4; i++) wr(REGS[i], 32'h0);
        wr(PR, 32'h40);
        pulse(2'h3);
        quiet(20);
        rd(TC, 32'hA0);
        wr(E1, 32'h82);
        wait_call(1);
        wr(E1, 32'h8A);
        wait_call(3);
        pulse(2'h1);
        quiet(40);
        do_return();
        quiet(40);
        do_return();
        wait_call(1);
        do_return();
        wr(E1, 32'h02);
        pulse(2'h1);
        quiet(40);
        rd(TC, 32'h20);
        wr(E1, 32'h82);
        wait_call(1);
        do_return();
        wr(TC, 32'h05);
        pins(4'hC);
        pins(4'hF);
        rd(TC, 32'h0F);
        wr(E1, 32'h85);
        wait_call(0);
        do_return();
        wait_call(2);
        do_return();
        rd(TC, 32'h05);
        wr(E1, 32'h00);
        wr(TC, 32'h00);
        pins(4'hC);
        rd(TC, 32'h0A);
        pins(4'hF);
        rd(TC, 32'h00);
        wr(PR, 32'h0);
        src <= 3'h7;
        pins(4'h3);
        rd(XR, 32'h3E);
        wr(E2, 32'h3E);
        wr(E1, 32'h80);
        for (int k = 6; k < 11; k++) begin
            wait_call(k);
            do_return();
        end
        src <= 3'h0;
        pins(4'hF);
        rd(XR, 32'h0);
        for (int k = 0; k < 2; k++) begin
            wr(E1, (k == 1) ? 32'h80 : 32'h90);
            wr(E3, 32'(k));
            ser <= 2'(1 << k);
            wait_call(4 + k);
            ser <= 2'h0;
            do_return();
        end
        give_verdict();
    end
endmodule
